// File: dv/lemc_host_model.sv
`timescale 1ns/1ps
`include "lemc_map.svh"
module lemc_host_model (
  input  wire logic                 clock_in,  // System clock.
  input  wire logic                 wide_in,   // 1: 16-bit bus.
  output logic [7:0]                addr_out,  // Byte address.
  output logic                      wr_out,    // Write strobe.
  output logic                      rd_out,    // Read strobe.
  output lemc_pkg::lemc_word_t      wdata_out, // Write data.
  input  wire lemc_pkg::lemc_word_t rdata_in   // Read data.
);
  import lemc_pkg::*;
  // Bus idle at time zero.
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end
  // A released bus shows the inverse so stale values cannot pass.
  task automatic write(input logic [7:0] a, input lemc_word_t d);
    @(negedge clock_in);
    addr_out = a;
    wdata_out = (wide_in && a == `LEMC_ADDR_CMD) ? {8'h00, d[7:0]} : d;
    wr_out = 1'b1;
    @(negedge clock_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~wdata_out;
  endtask : write
  task automatic read(input logic [7:0] a, output lemc_word_t d);
    @(negedge clock_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clock_in);
    rd_out = 1'b0;
    addr_out = ~a;
    @(negedge clock_in);
    d = rdata_in;
  endtask : read
endmodule : lemc_host_model

// File: dv/lemc_top_sva.sv
`timescale 1ns/1ps
`include "lemc_map.svh"
module lemc_top_sva (
  input wire logic                 clock_in,           // Clock.
  input wire logic                 rst_in,             // Reset.
  input wire logic [7:0]           addr_in,            // Address.
  input wire logic                 wr_in,              // Write.
  input wire lemc_pkg::lemc_word_t wdata_in,           // Data.
  input wire lemc_pkg::lemc_word_t status_in,          // Events.
  input wire logic                 token_in,           // Token.
  input wire logic                 irq_out,            // Interrupt.
  input wire logic                 tx_start_out,       // Start.
  input wire logic                 clr_next_fault_out, // Clear.
  input wire logic                 warn_restart_out,   // Restart.
  input wire logic                 clr_por_out,        // Clear.
  input wire logic                 clr_refusal_out,    // Clear.
  input wire logic                 clr_reconfig_out    // Clear.
);
  import lemc_pkg::*;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // Mask copy, since the pins do not show the register itself.
  lemc_word_t mask_copy;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mask_copy <= `LEMC_MASK_RST;
    end else if (wr_in && addr_in == `LEMC_ADDR_MASK) begin
      mask_copy <= wdata_in;
    end
  end
  sequence cmd_wr(logic [7:0] code);
    wr_in && addr_in == `LEMC_ADDR_CMD && wdata_in[7:0] == code;
  endsequence
  sequence upper_wr;
    wr_in && addr_in == 8'h17;
  endsequence
  // Bits 0 and 8 are made inside, so only the others are judged from pins.
  irq_raise_a: assert property (|(status_in & mask_copy & 16'hfefe) |-> irq_out)
    else $error("masked event gave no interrupt");
  // Bits 0 and 8 come from inside, so their mask bits alone may explain the line.
  irq_cause_a: assert property (irq_out |-> |(status_in & mask_copy & 16'hfefe) || mask_copy[0] || mask_copy[8])
    else $error("interrupt without cause");
  next_clear_a: assert property (cmd_wr(8'h09) |=> clr_next_fault_out)
    else $error("next fault clear missing");
  warn_restart_a: assert property (cmd_wr(8'h0a) |=> warn_restart_out)
    else $error("warning restart missing");
  pair_clear_a: assert property (cmd_wr(8'h0e) |=> clr_por_out && !clr_reconfig_out)
    else $error("pair clear wrong");
  pair_tied_a: assert property (clr_por_out == clr_refusal_out)
    else $error("pair cleared alone");
  reconfig_only_a: assert property (cmd_wr(8'h16) |=> clr_reconfig_out && !clr_por_out)
    else $error("reconfig clear wrong");
  all_clear_a: assert property (cmd_wr(8'h1e) |=> clr_por_out && clr_reconfig_out)
    else $error("triple clear wrong");
  upper_ignored_a: assert property (upper_wr |=> !(clr_por_out || clr_reconfig_out))
    else $error("upper byte write acted");
  send_token_a: assert property (cmd_wr(8'h03) ##1 token_in |-> tx_start_out)
    else $error("armed send did not start");
  start_cause_a: assert property (tx_start_out |-> token_in)
    else $error("start without token");
endmodule : lemc_top_sva
bind lemc_top lemc_top_sva u_sva (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_in(wr_in), .wdata_in(wdata_in), .status_in(status_in), .token_in(token_in),
  .irq_out(irq_out), .tx_start_out(tx_start_out), .clr_next_fault_out(clr_next_fault_out),
  .warn_restart_out(warn_restart_out), .clr_por_out(clr_por_out),
  .clr_refusal_out(clr_refusal_out), .clr_reconfig_out(clr_reconfig_out));

// File: dv/tb_link_event_mask_command_sid.sv
`timescale 1ns/1ps
`include "lemc_map.svh"
module tb_link_event_mask_command_sid;
  import lemc_pkg::*;
  logic clock_in = 1'b0, rst_in = 1'b1, wide = 1'b0, token_in = 1'b0, sty1 = 1'b0, sty0 = 1'b0;
  logic pkt_valid_in = 1'b0, pkt_to_me_in = 1'b0, match_clr_in = 1'b0;
  logic [7:0] addr_in;
  logic wr_in, rd_in, irq_out, tx_start_out, c_next, c_warn, c_por, c_ref, c_rcf;
  lemc_word_t wdata_in, rdata_out, rd_val, m, st, status_in = 16'h0000;
  lemc_sid_t pkt_sid_in = 5'h00, a, b;
  logic [31:0] seed = 32'd60;
  logic [7:0] codes [5] = '{8'h09, 8'h0a, 8'h0e, 8'h16, 8'h1e};
  logic [1:0] styles [3] = '{2'b00, 2'b11, 2'b10};
  int fail_count = 0;
  int checks = 0;
  always #2.5 clock_in = ~clock_in;
  lemc_host_model host (.clock_in(clock_in), .wide_in(wide), .addr_out(addr_in),
    .wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in), .rdata_in(rdata_out));
  lemc_top uut (.clock_in(clock_in), .rst_in(rst_in), .wide_bus_select_in(wide),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .status_in(status_in), .token_in(token_in),
    .transmit_style_in(sty1), .single_shot_in(sty0), .pkt_valid_in(pkt_valid_in),
    .pkt_to_me_in(pkt_to_me_in), .pkt_sid_in(pkt_sid_in), .match_clr_in(match_clr_in),
    .irq_out(irq_out), .tx_start_out(tx_start_out), .clr_next_fault_out(c_next),
    .warn_restart_out(c_warn), .clr_por_out(c_por), .clr_refusal_out(c_ref),
    .clr_reconfig_out(c_rcf));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // The generator keeps 32 bits of state but hands out one bus word.
  function automatic lemc_word_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  // Pulse order is next, warn, power-on, refusal, reconfig.
  function automatic lemc_word_t exp_pulses(input logic [7:0] c);
    return {11'h000, c == 8'h09, c == 8'h0a, c == 8'h0e || c == 8'h1e,
            c == 8'h0e || c == 8'h1e, c == 8'h16 || c == 8'h1e};
  endfunction : exp_pulses
  function automatic lemc_word_t exp_sids(input lemc_sid_t own, input lemc_sid_t last);
    return {3'b000, own, 3'b000, last};
  endfunction : exp_sids
  task automatic check(input lemc_word_t seen, input lemc_word_t exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // An idle cycle follows each pulse so no input is set twice in one step.
  task automatic tok(input logic exp);
    token_in = 1'b1;
    #1 check(lemc_word_t'(tx_start_out), lemc_word_t'(exp), "send start");
    @(negedge clock_in) token_in = 1'b0;
    @(negedge clock_in);
  endtask : tok
  task automatic pkt(input logic me, input lemc_sid_t sid);
    pkt_valid_in = 1'b1;
    pkt_to_me_in = me;
    pkt_sid_in = sid;
    @(negedge clock_in) pkt_valid_in = 1'b0;
    @(negedge clock_in);
  endtask : pkt
  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Watchdog, well beyond the few hundred cycles the run needs.
  initial begin
    #100000;
    fail_count++;
    results();
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_in);
    @(negedge clock_in) rst_in = 1'b0;
    for (int r = 0; r < 4; r++) begin
      host.read(8'h14 + 8'(2 * r), rd_val);
      check(rd_val, 16'h0000, "reset value");
    end
    // Random masks and events, then one mask bit at a time.
    for (int i = 0; i < 24; i++) begin
      m = (i < 8) ? xs() : (16'h0001 << (i - 8));
      host.write(`LEMC_ADDR_MASK, m);
      st = xs();
      status_in = (i < 8) ? st : (st | m);
      #1 check(lemc_word_t'(irq_out), lemc_word_t'(|(status_in & m & 16'hfefe) | m[0]), "irq");
      host.read(`LEMC_ADDR_MASK, rd_val);
      check(rd_val, m, "mask readback");
    end
    status_in = 16'h0000;
    // Each clear code on both bus widths, with an upper byte access after it.
    for (int w = 0; w < 2; w++) begin
      wide = w[0];
      foreach (codes[k]) begin
        st = xs();
        host.write(`LEMC_ADDR_CMD, {st[15:8], codes[k]});
        check({11'h000, c_next, c_warn, c_por, c_ref, c_rcf}, exp_pulses(codes[k]), "clears");
        host.write(8'h17, xs());
        check({11'h000, c_next, c_warn, c_por, c_ref, c_rcf}, 16'h0000, "upper byte");
        host.read(`LEMC_ADDR_CMD, rd_val);
        check(rd_val, {8'h00, codes[k]}, "command readback");
      end
    end
    // Free, single-shot and continuous styles; mask bit 0 shows availability.
    host.write(`LEMC_ADDR_MASK, 16'h0001);
    foreach (styles[s]) begin
      {sty1, sty0} = styles[s];
      host.write(`LEMC_ADDR_CMD, {8'h00, `LEMC_CMD_SEND});
      check(lemc_word_t'(irq_out), 16'h0000, "pending");
      tok(1'b1);
      tok(styles[s] == 2'b10);
      check(lemc_word_t'(irq_out), lemc_word_t'(styles[s] != 2'b10), "available");
    end
    // Cancel of continuous sending takes hold at the next token.
    host.write(`LEMC_ADDR_CMD, {8'h00, `LEMC_CMD_CANCEL});
    check(lemc_word_t'(irq_out), 16'h0000, "cancel waits");
    tok(1'b0);
    check(lemc_word_t'(irq_out), 16'h0001, "cancelled");
    tok(1'b0);
    host.write(`LEMC_ADDR_CMD, {8'h00, `LEMC_CMD_SEND});
    tok(1'b1);
    host.write(`LEMC_ADDR_CMD, {8'h00, `LEMC_CMD_CANCEL});
    tok(1'b0);
    // Sender records and the search match.
    st = xs();
    a = st[4:0];
    b = st[12:8];
    pkt(1'b0, a);
    host.read(`LEMC_ADDR_SIDS, rd_val);
    check(rd_val, exp_sids(5'h00, a), "last sender");
    pkt(1'b1, b);
    pkt(1'b0, ~b);
    host.read(`LEMC_ADDR_SIDS, rd_val);
    check(rd_val, exp_sids(b, ~b), "own sender");
    host.write(`LEMC_ADDR_SEARCH, st);
    host.read(`LEMC_ADDR_SEARCH, rd_val);
    check(rd_val, {11'h000, st[4:0]}, "search readback");
    // Earlier packets may have matched the reset search value, so start clean.
    match_clr_in = 1'b1;
    @(negedge clock_in) match_clr_in = 1'b0;
    host.write(`LEMC_ADDR_MASK, 16'h0100);
    pkt(1'b0, ~a);
    check(lemc_word_t'(irq_out), 16'h0000, "no match");
    pkt(1'b1, a);
    check(lemc_word_t'(irq_out), 16'h0001, "match");
    match_clr_in = 1'b1;
    @(negedge clock_in) match_clr_in = 1'b0;
    check(lemc_word_t'(irq_out), 16'h0000, "match cleared");
    results();
  end
endmodule : tb_link_event_mask_command_sid

// File: logic/lemc_cmd_if.sv
`timescale 1ns/1ps
// Decoded one-cycle command strobes passed from the bus front to the engine.
interface lemc_cmd_if;
  logic send;
  logic cancel;
  logic clr_next;
  logic clr_warn;
  logic clr_por;
  logic clr_rcf;
  modport src (output send, cancel, clr_next, clr_warn, clr_por, clr_rcf);
  modport dst (input send, cancel, clr_next, clr_warn, clr_por, clr_rcf);
endinterface : lemc_cmd_if

// File: logic/lemc_map.svh
`ifndef LEMC_MAP_SVH
`define LEMC_MAP_SVH
// Functional notes
// - A set mask bit lets its event status bit drive the interrupt output.
// - All sixteen status bits can interrupt; mask bits align with status bits.
// - Narrow bus ignores command upper byte; lower-byte write executes command.
// - Reading command register returns last written command code.
// - Code 03h arms a send that starts at next token arrival.
// - Continuous remote-buffer style resends automatically at every later token.
// - Code 01h withdraws pending send at token arrival; then available reads 1.
// - Cancel halts continuous sending; a new send command resumes it.
// - Transmitter available reads 0 while a send command is pending or continuous sending repeats.
// - Code 09h clears the next-node fault in the core diagnostic register.
// - Code 0Ah restarts warning timer, clears its fault and remote receive flags.
// - Code 0Eh clears power-on and excess-refusal flags together.
// - Code 16h clears only the reconfiguration flag.
// - Code 1Eh clears power-on, excess-refusal and reconfiguration flags.
// - Upper field holds sender ID of last packet addressed to this node.
// - Lower field holds sender ID of last packet received.
// - Sender ID equal to search ID sets the source match flag.

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define LEMC_ADDR_MASK     8'h14
`define LEMC_ADDR_CMD      8'h16
`define LEMC_ADDR_SIDS     8'h18
`define LEMC_ADDR_SEARCH   8'h1a

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define LEMC_CMD_SEND      8'h03
`define LEMC_CMD_CANCEL    8'h01
`define LEMC_CMD_CLR_NEXT  8'h09
`define LEMC_CMD_CLR_WARN  8'h0a
`define LEMC_CMD_CLR_POR   8'h0e
`define LEMC_CMD_CLR_RCF   8'h16
`define LEMC_CMD_CLR_ALL   8'h1e

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LEMC_SID_W         5
`define LEMC_OWN_SID_LSB   8
`define LEMC_STAT_AVAIL    0
`define LEMC_STAT_MATCH    8
`define LEMC_STAT_WARN     12
`define LEMC_MASK_RST      16'h0000
`define LEMC_CMD_RST       8'h00
`define LEMC_SID_RST       5'h00
`endif

// File: logic/lemc_pkg.sv
package lemc_pkg;
  typedef logic [15:0] lemc_word_t;
  typedef logic [4:0]  lemc_sid_t;
  typedef enum logic [2:0] {
    LEMC_IDLE    = 3'b001,
    LEMC_PENDING = 3'b010,
    LEMC_REPEAT  = 3'b100
  } lemc_tx_state_t;
endpackage : lemc_pkg

// File: logic/lemc_top.sv
`timescale 1ns/1ps
`include "lemc_map.svh"
// ----------------------------------------------------------------------------
// Mask, command, sender-ID registers of the link controller host port.
// ----------------------------------------------------------------------------
module lemc_top (
  input  wire logic               clock_in,          // System clock, 200 MHz.
  input  wire logic               rst_in,            // Synchronous reset, active high.
  input  wire logic               wide_bus_select_in, // 1: 16-bit host bus.
  input  wire logic [7:0]         addr_in,           // Byte address.
  input  wire logic               wr_in,             // Write strobe, one cycle.
  input  wire logic               rd_in,             // Read strobe, one cycle.
  input  wire lemc_pkg::lemc_word_t wdata_in,        // Write data.
  output lemc_pkg::lemc_word_t    rdata_out,         // Registered read data.
  input  wire lemc_pkg::lemc_word_t status_in,       // Other event status bits.
  input  wire logic               token_in,          // Token arrival pulse.
  input  wire logic               transmit_style_in, // Transmit style.
  input  wire logic               single_shot_in,    // Single shot select.
  input  wire logic               pkt_valid_in,      // Packet received pulse.
  input  wire logic               pkt_to_me_in,      // Packet was addressed to us.
  input  wire lemc_pkg::lemc_sid_t pkt_sid_in,       // Sender ID of packet.
  input  wire logic               match_clr_in,      // Source match clear pulse.
  output logic                    irq_out,           // Interrupt, active high.
  output logic                    tx_start_out,      // Send start pulse.
  output logic                    clr_next_fault_out, // Next node fault clear.
  output logic                    warn_restart_out,  // Warning timer restart.
  output logic                    clr_por_out,       // Power-on flag clear.
  output logic                    clr_refusal_out,   // Excess refusal clear.
  output logic                    clr_reconfig_out   // Reconfiguration clear.
);
  import lemc_pkg::*;

  lemc_cmd_if cmd ();

  lemc_word_t event_interrupt_mask;
  logic [7:0] link_command;
  lemc_sid_t  last_sender_id;
  lemc_sid_t  last_own_sender_id;
  lemc_sid_t  search_sender_id;
  logic       source_match_flag;
  logic       avail;
  lemc_word_t event_status;
  logic       cmd_wr;

  // Address match only: a write acts at the exact base address, whatever the bus width.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction : hit

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  // Upper byte at base+1 is ignored and only wdata_in[7:0] is decoded, whatever the bus width.
  assign cmd_wr = wr_in & hit(addr_in, `LEMC_ADDR_CMD);

  // Strobes last one cycle so each command acts exactly once.
  assign cmd.send     = cmd_wr & (wdata_in[7:0] == `LEMC_CMD_SEND);
  assign cmd.cancel   = cmd_wr & (wdata_in[7:0] == `LEMC_CMD_CANCEL);
  assign cmd.clr_next = cmd_wr & (wdata_in[7:0] == `LEMC_CMD_CLR_NEXT);
  assign cmd.clr_warn = cmd_wr & (wdata_in[7:0] == `LEMC_CMD_CLR_WARN);
  assign cmd.clr_por  = cmd_wr & ((wdata_in[7:0] == `LEMC_CMD_CLR_POR)
                                | (wdata_in[7:0] == `LEMC_CMD_CLR_ALL));
  assign cmd.clr_rcf  = cmd_wr & ((wdata_in[7:0] == `LEMC_CMD_CLR_RCF)
                                | (wdata_in[7:0] == `LEMC_CMD_CLR_ALL));

  // Clear pulses to the core flags; power-on and refusal are never split.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      clr_next_fault_out <= 1'b0;
      warn_restart_out   <= 1'b0;
      clr_por_out        <= 1'b0;
      clr_refusal_out    <= 1'b0;
      clr_reconfig_out   <= 1'b0;
    end else begin
      clr_next_fault_out <= cmd.clr_next;
      warn_restart_out   <= cmd.clr_warn;
      clr_por_out        <= cmd.clr_por;
      clr_refusal_out    <= cmd.clr_por;
      clr_reconfig_out   <= cmd.clr_rcf;
    end
  end

  // ----------------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      event_interrupt_mask <= `LEMC_MASK_RST;
    end else if (wr_in && hit(addr_in, `LEMC_ADDR_MASK)) begin
      event_interrupt_mask <= wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      link_command <= `LEMC_CMD_RST;
    end else if (cmd_wr) begin
      link_command <= wdata_in[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      search_sender_id <= `LEMC_SID_RST;
    end else if (wr_in && hit(addr_in, `LEMC_ADDR_SEARCH)) begin
      search_sender_id <= wdata_in[`LEMC_SID_W-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Received sender IDs and match flag
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      last_sender_id     <= `LEMC_SID_RST;
      last_own_sender_id <= `LEMC_SID_RST;
    end else if (pkt_valid_in) begin
      last_sender_id <= pkt_sid_in;
      if (pkt_to_me_in) begin
        last_own_sender_id <= pkt_sid_in;
      end
    end
  end

  // Set wins over clear so a match in the clearing cycle is kept.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      source_match_flag <= 1'b0;
    end else if (pkt_valid_in && pkt_sid_in == search_sender_id) begin
      source_match_flag <= 1'b1;
    end else if (match_clr_in) begin
      source_match_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Transmit control
  // ----------------------------------------------------------------------------
  lemc_tx_ctrl u_tx (
    .clock_in          (clock_in),
    .rst_in            (rst_in),
    .cmd               (cmd),
    .token_in          (token_in),
    .transmit_style_in (transmit_style_in),
    .single_shot_in    (single_shot_in),
    .tx_start_out      (tx_start_out),
    .avail_out         (avail)
  );

  // ----------------------------------------------------------------------------
  // Status merge, interrupt and readback
  // ----------------------------------------------------------------------------
  always_comb begin
    event_status                   = status_in;
    event_status[`LEMC_STAT_AVAIL] = avail;
    event_status[`LEMC_STAT_MATCH] = source_match_flag;
  end

  // Combinational so the line follows status in the same cycle.
  assign irq_out = |(event_status & event_interrupt_mask);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      unique case (addr_in)
        `LEMC_ADDR_MASK:   rdata_out <= event_interrupt_mask;
        `LEMC_ADDR_CMD:    rdata_out <= {8'h00, link_command};
        `LEMC_ADDR_SIDS:   rdata_out <= {3'h0, last_own_sender_id, 3'h0, last_sender_id};
        `LEMC_ADDR_SEARCH: rdata_out <= {11'h000, search_sender_id};
        default:           rdata_out <= 16'h0000;
      endcase
    end
  end
endmodule : lemc_top

// File: logic/lemc_tx_ctrl.sv
`timescale 1ns/1ps
`include "lemc_map.svh"
// ----------------------------------------------------------------------------
// Send arming state machine and transmitter-available flag.
// ----------------------------------------------------------------------------
module lemc_tx_ctrl (
  input  wire logic clock_in,         // System clock.
  input  wire logic rst_in,           // Synchronous reset, active high.
  lemc_cmd_if.dst   cmd,              // Command strobes.
  input  wire logic token_in,         // One-cycle token arrival pulse.
  input  wire logic transmit_style_in, // 1: remote-buffer style.
  input  wire logic single_shot_in,   // 1: single shot in remote-buffer style.
  output logic      tx_start_out,     // One-cycle send start pulse.
  output logic      avail_out         // Transmitter available flag.
);
  import lemc_pkg::*;

  lemc_tx_state_t state;
  logic           cancel_req;
  logic           continuous;

  // Continuous resend only in remote-buffer style without single shot.
  assign continuous = transmit_style_in & ~single_shot_in;

  // Cancel stays requested until the token or a new send command resolves it, since the engine may be busy.
  always_ff @(posedge clock_in) begin
    if (rst_in || cmd.send) begin
      cancel_req <= 1'b0;
    end else if (token_in) begin
      // A cancel in the token cycle acts directly, so nothing is left latched.
      cancel_req <= 1'b0;
    end else if (cmd.cancel && state != LEMC_IDLE) begin
      cancel_req <= 1'b1;
    end
  end

  // State moves on send command and on token arrival.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= LEMC_IDLE;
    end else if (cmd.send) begin
      state <= LEMC_PENDING;
    end else if (token_in) begin
      unique case (state)
        LEMC_IDLE: begin
          state <= LEMC_IDLE;
        end
        LEMC_PENDING, LEMC_REPEAT: begin
          if (cancel_req || cmd.cancel) begin
            state <= LEMC_IDLE;
          end else if (continuous) begin
            state <= LEMC_REPEAT;
          end else begin
            state <= LEMC_IDLE;
          end
        end
        default: begin
          state <= LEMC_IDLE;
        end
      endcase
    end
  end

  // A send starts only on token arrival with an armed, uncancelled request.
  assign tx_start_out = token_in & (state != LEMC_IDLE) & ~cancel_req
                        & ~cmd.cancel & ~cmd.send;
  // Available reads 0 only while a send is armed; repeat mode stays armed.
  assign avail_out    = (state == LEMC_IDLE);
endmodule : lemc_tx_ctrl
